/* hw/iefl_flag_bank.sv */
// Bank of sticky flags: hardware sets, software writes or clears
`timescale 1ns/1ps
module iefl_flag_bank #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // Clock, reset and enable
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clkEn,
  // Hardware events, one-cycle pulses
  input wire logic [WIDTH-1:0] hwSet,
  // Software access
  input wire logic [WIDTH-1:0] swClear,
  input wire logic [WIDTH-1:0] swSet,
  // Flag state
  output logic [WIDTH-1:0] flags
);

  logic [WIDTH-1:0] flags_reg;
  logic [WIDTH-1:0] flags_next;

  // A hardware set in the same cycle as a clear wins, so no event is lost
  assign flags_next = (flags_reg & ~swClear) | swSet | hwSet;
  assign flags = flags_reg;

  // Flags only change while the clock enable is high
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      flags_reg <= RESET_VALUE;
    end else if (clkEn) begin
      flags_reg <= flags_next;
    end
  end

  // A hardware event with the clock enable high leaves its flag set in the next cycle
  a_set_wins: assert property (@(posedge core_clk) disable iff (!resetn)
    clkEn && (hwSet != '0) |=> ((flags_reg & $past(hwSet)) == $past(hwSet)))
    else $error("flag event lost");

endmodule : iefl_flag_bank

/* hw/iefl_pkg.sv */
// Package with the register map, field positions and reset values
package iefl_pkg;
  // Register port width and register offsets
  localparam int ADDR_W = 9;
  localparam logic [8:0] CORE_CTRL_B0 = 9'h00B;
  localparam logic [8:0] CORE_CTRL_B1 = 9'h08B;
  localparam logic [8:0] CORE_CTRL_B2 = 9'h10B;
  localparam logic [8:0] CORE_CTRL_B3 = 9'h18B;
  localparam logic [8:0] PERIPH_FLAGS = 9'h00C;
  localparam logic [8:0] PERIPH_ENABLE = 9'h08C;
  localparam logic [8:0] STATUS_EVENTS = 9'h1F0;
  localparam logic [8:0] STATUS_CLEAR = 9'h1F1;
  localparam logic [8:0] STATUS_ENABLE = 9'h1F2;

  // Core interrupt control register fields
  localparam int GLOBAL_EN_BIT = 7;
  localparam int PERIPH_EN_BIT = 6;
  localparam int T0_EN_BIT = 5;
  localparam int EDGE_EN_BIT = 4;
  localparam int PORT_EN_BIT = 3;
  localparam int T0_FLAG_BIT = 2;
  localparam int EDGE_FLAG_BIT = 1;
  localparam int PORT_FLAG_BIT = 0;

  // Peripheral enable and flag fields, same layout in both registers
  localparam int DISPLAY_BIT = 7;
  localparam int CONVERTER_BIT = 6;
  localparam int SERIAL_BIT = 3;
  localparam int CAPTURE_BIT = 2;
  localparam int PERIOD_BIT = 1;
  localparam int T1_BIT = 0;
  localparam int PERIPH_SRC_N = 6;

  // Status event register fields
  localparam int ST_T0_BIT = 0;
  localparam int ST_EDGE_BIT = 1;
  localparam int ST_PORT_BIT = 2;
  localparam int ST_PERIPH_BIT = 3;
  localparam int ST_REQUEST_BIT = 4;
  localparam int STATUS_N = 5;

  // Reset values
  localparam logic [7:0] CORE_CTRL_RST = 8'h00;
  localparam logic [7:0] PERIPH_ENABLE_RST = 8'h00;
  localparam logic [7:0] PERIPH_FLAGS_RST = 8'h00;
  localparam logic [7:0] STATUS_ENABLE_RST = 8'h00;
endpackage : iefl_pkg

/* hw/iefl_top.sv */
// Interrupt enable and flag registers with request and status interrupt
//
// Function
// - Core control register readable at four bank addresses
// - Global enable bit 7 gates every request
// - Peripheral enable bit 6 gates peripheral sources
// - Bit 5 enables timer zero overflow
// - Bit 4 enables external edge pin
// - Edge pin flag set by event, software clears
// - Flags set regardless of any enable
// - Peripheral enable register at one address
// - Peripheral bit 7 enables display interrupt
// - Peripheral bit 6 enables converter interrupt
// - Peripheral bits 5 and 4 read zero
// - Peripheral bit 1 enables period match
// - Peripheral bit 0 enables timer one overflow
// - Period match flag sticky until software clears
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
module iefl_top #(
  parameter int ADDR_W = iefl_pkg::ADDR_W
) (
  // Clock, reset and clock enable
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clkEn,
  // Register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  // Core event sources, one-cycle pulses
  input wire logic timerZeroOverflow,
  input wire logic edgePinEvent,
  input wire logic portChangeEvent,
  // Peripheral event sources, one-cycle pulses
  input wire logic displayEvent,
  input wire logic converterEvent,
  input wire logic serialPortEvent,
  input wire logic captureCompareEvent,
  input wire logic periodMatchEvent,
  input wire logic timerOneOverflow,
  // Interrupt outputs
  output logic irqRequest,
  output logic statusIrq
);

  localparam int PN = iefl_pkg::PERIPH_SRC_N;
  localparam int SN = iefl_pkg::STATUS_N;

  // Spread six packed peripheral bits onto the register layout
  function automatic logic [7:0] periphLayout(input logic [PN-1:0] v);
    periphLayout = {v[5:4], 2'b00, v[3:0]};
  endfunction : periphLayout

  // Core register: enables in flops here, flags in a flag bank
  logic [4:0] coreEn_reg;
  logic [4:0] coreEn_next;
  logic [2:0] coreFlags;
  logic [PN-1:0] periphEn_reg;
  logic [PN-1:0] periphEn_next;
  logic [PN-1:0] periphFlags;
  logic [SN-1:0] statusEn_reg;
  logic [SN-1:0] statusEn_next;
  logic [SN-1:0] statusFlags;
  logic [7:0] regRdData_reg;
  logic [7:0] regRdData_next;
  logic irqRequest_reg;
  logic irqRequest_next;
  logic statusIrq_reg;
  logic statusIrq_next;

  // Address decode; the core register answers in every bank
  wire coreSel = (regAddr == iefl_pkg::CORE_CTRL_B0) ||
                 (regAddr == iefl_pkg::CORE_CTRL_B1) ||
                 (regAddr == iefl_pkg::CORE_CTRL_B2) ||
                 (regAddr == iefl_pkg::CORE_CTRL_B3);
  wire pieSel = (regAddr == iefl_pkg::PERIPH_ENABLE);
  wire pirSel = (regAddr == iefl_pkg::PERIPH_FLAGS);
  wire stSel = (regAddr == iefl_pkg::STATUS_EVENTS);
  wire stClrSel = (regAddr == iefl_pkg::STATUS_CLEAR);
  wire stEnSel = (regAddr == iefl_pkg::STATUS_ENABLE);

  // Write strobes, frozen with the clock enable
  wire wrAct = clkEn && regWrite;
  wire coreWr = wrAct && coreSel;
  wire pieWr = wrAct && pieSel;
  wire pirWr = wrAct && pirSel;
  wire stClrWr = wrAct && stClrSel;
  wire stEnWr = wrAct && stEnSel;

  // Packed peripheral write data, unimplemented bits dropped
  wire [PN-1:0] periphWrPacked = {regWrData[7:6], regWrData[3:0]};

  // Named enable and flag bits
  wire globalIrqEnable = coreEn_reg[4];
  wire peripheralIrqEnable = coreEn_reg[3];
  wire timerZeroOverflowEnable = coreEn_reg[2];
  wire edgePinIrqEnable = coreEn_reg[1];
  wire portChangeIrqEnable = coreEn_reg[0];
  wire timerZeroOverflowFlag = coreFlags[2];
  wire edgePinIrqFlag = coreFlags[1];
  wire portChangeIrqFlag = coreFlags[0];

  wire [7:0] coreValue = {coreEn_reg, coreFlags};
  wire [7:0] pieValue = periphLayout(periphEn_reg);
  wire [7:0] pirValue = periphLayout(periphFlags);

  // Core flags: written value clears or sets, events set
  wire [2:0] coreHwSet = {timerZeroOverflow, edgePinEvent,
                          portChangeEvent};
  wire [2:0] coreSwClear = coreWr ? ~regWrData[2:0] : 3'h0;
  wire [2:0] coreSwSet = coreWr ? regWrData[2:0] : 3'h0;

  iefl_flag_bank #(
    .WIDTH(3),
    .RESET_VALUE(iefl_pkg::CORE_CTRL_RST[2:0])
  ) coreFlagBank (
    .core_clk(core_clk),
    .resetn(resetn),
    .clkEn(clkEn),
    .hwSet(coreHwSet),
    .swClear(coreSwClear),
    .swSet(coreSwSet),
    .flags(coreFlags)
  );

  // Peripheral flags, packed: display, converter, serial, capture,
  // period match, timer one
  wire [PN-1:0] periphHwSet = {displayEvent, converterEvent,
                               serialPortEvent, captureCompareEvent,
                               periodMatchEvent, timerOneOverflow};
  wire [PN-1:0] periphSwClear = pirWr ? ~periphWrPacked : '0;
  wire [PN-1:0] periphSwSet = pirWr ? periphWrPacked : '0;

  iefl_flag_bank #(
    .WIDTH(PN),
    .RESET_VALUE({iefl_pkg::PERIPH_FLAGS_RST[7:6],
                  iefl_pkg::PERIPH_FLAGS_RST[3:0]})
  ) periphFlagBank (
    .core_clk(core_clk),
    .resetn(resetn),
    .clkEn(clkEn),
    .hwSet(periphHwSet),
    .swClear(periphSwClear),
    .swSet(periphSwSet),
    .flags(periphFlags)
  );

  // Request: enabled core sources, or enabled peripherals behind their gate
  wire [2:0] coreEnVec = {timerZeroOverflowEnable, edgePinIrqEnable,
                          portChangeIrqEnable};
  wire coreHit = |(coreEnVec & coreFlags);
  wire periphHit = |(periphEn_reg & periphFlags);
  assign irqRequest_next = globalIrqEnable &&
                           (coreHit || (peripheralIrqEnable && periphHit));

  // Status events; a request edge also counts so software can see it
  wire requestRise = irqRequest_next && !irqRequest_reg;
  wire [SN-1:0] statusHwSet = {requestRise, |periphHwSet,
                               portChangeEvent, edgePinEvent,
                               timerZeroOverflow};
  wire [SN-1:0] statusSwClear = stClrWr ? regWrData[SN-1:0] : '0;

  iefl_flag_bank #(
    .WIDTH(SN),
    .RESET_VALUE('0)
  ) statusBank (
    .core_clk(core_clk),
    .resetn(resetn),
    .clkEn(clkEn),
    .hwSet(statusHwSet),
    .swClear(statusSwClear),
    .swSet('0),
    .flags(statusFlags)
  );

  assign statusIrq_next = |(statusFlags & statusEn_reg);

  // Enable register next values
  assign coreEn_next = coreWr ? regWrData[7:3] : coreEn_reg;
  assign periphEn_next = pieWr ? periphWrPacked : periphEn_reg;
  assign statusEn_next = stEnWr ? regWrData[SN-1:0] : statusEn_reg;

  // Read mux; unmapped and write-only addresses read zero
  wire [7:0] rdMux = coreSel ? coreValue :
                     pieSel ? pieValue :
                     pirSel ? pirValue :
                     stSel ? {{(8-SN){1'b0}}, statusFlags} :
                     stEnSel ? {{(8-SN){1'b0}}, statusEn_reg} :
                     8'h00;
  // Read data stands only in the cycle after the strobe
  assign regRdData_next = regRead ? rdMux : 8'h00;

  // Enable registers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      coreEn_reg <= iefl_pkg::CORE_CTRL_RST[7:3];
      periphEn_reg <= {iefl_pkg::PERIPH_ENABLE_RST[7:6],
                       iefl_pkg::PERIPH_ENABLE_RST[3:0]};
      statusEn_reg <= iefl_pkg::STATUS_ENABLE_RST[SN-1:0];
    end else if (clkEn) begin
      coreEn_reg <= coreEn_next;
      periphEn_reg <= periphEn_next;
      statusEn_reg <= statusEn_next;
    end
  end

  // Output flops; request lags the flags by one cycle
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      regRdData_reg <= 8'h00;
      irqRequest_reg <= 1'b0;
      statusIrq_reg <= 1'b0;
    end else if (clkEn) begin
      regRdData_reg <= regRdData_next;
      irqRequest_reg <= irqRequest_next;
      statusIrq_reg <= statusIrq_next;
    end
  end

  assign regRdData = regRdData_reg;
  assign irqRequest = irqRequest_reg;
  assign statusIrq = statusIrq_reg;

  // Checks on the register and request behaviour
  sequence coreWriteS;
    clkEn && regWrite && (regAddr == iefl_pkg::CORE_CTRL_B0);
  endsequence

  sequence mirrorReadS;
    clkEn && regRead && (regAddr == iefl_pkg::CORE_CTRL_B3);
  endsequence

  a_core_mirror: assert property (
    @(posedge core_clk) disable iff (!resetn)
    coreWriteS ##1 (mirrorReadS and !(clkEn && regWrite))
    |=> (regRdData[7:3] == $past(regWrData[7:3], 2)))
    else $error("core mirror reads differ");

  a_global_gate: assert property (
    @(posedge core_clk) disable iff (!resetn)
    clkEn && !coreEn_reg[4] |=> !irqRequest)
    else $error("request while global enable clear");

  a_periph_gate: assert property (
    @(posedge core_clk) disable iff (!resetn)
    clkEn && !coreEn_reg[3] && ((coreEnVec & coreFlags) == 3'h0)
    |=> !irqRequest)
    else $error("peripheral passed without its gate");

  a_t0_request: assert property (
    @(posedge core_clk) disable iff (!resetn)
    clkEn && coreEn_reg[4] && coreEn_reg[2] && coreFlags[2]
    |=> irqRequest)
    else $error("timer zero request missing");

  a_edge_request: assert property (
    @(posedge core_clk) disable iff (!resetn)
    clkEn && coreEn_reg[4] && coreEn_reg[1] && coreFlags[1]
    |=> irqRequest)
    else $error("edge pin request missing");

  a_t0_sticky: assert property (
    @(posedge core_clk) disable iff (!resetn)
    coreFlags[2] && !(coreWr && !regWrData[2]) |=> coreFlags[2])
    else $error("timer zero flag cleared by hardware");

  a_edge_set: assert property (
    @(posedge core_clk) disable iff (!resetn)
    clkEn && edgePinEvent && !coreEn_reg[4] |=> coreFlags[1][*2])
    else $error("edge flag not set or not held");

  a_pie_unimpl: assert property (
    @(posedge core_clk) disable iff (!resetn)
    clkEn && regRead && pieSel |=> (regRdData[5:4] == 2'b00))
    else $error("unimplemented enable bits read one");

  a_period_sticky: assert property (
    @(posedge core_clk) disable iff (!resetn)
    clkEn && periodMatchEvent ##1 !pirWr |=> periphFlags[1])
    else $error("period match flag not held");

  a_periph_request: assert property (
    @(posedge core_clk) disable iff (!resetn)
    clkEn && coreEn_reg[4] && coreEn_reg[3] && periphEn_reg[1] &&
    periphFlags[1] |=> irqRequest)
    else $error("peripheral request missing");

  a_status_level: assert property (
    @(posedge core_clk) disable iff (!resetn)
    clkEn && ((statusFlags & statusEn_reg) == '0) |=> !statusIrq)
    else $error("status interrupt without enabled bit");

  // Events set their flags whatever the enables say
  a_t0_flag_set: assert property (
    @(posedge core_clk) disable iff (!resetn)
    clkEn && timerZeroOverflow |=> timerZeroOverflowFlag)
    else $error("timer zero flag not set");

  a_edge_any_en: assert property (
    @(posedge core_clk) disable iff (!resetn)
    clkEn && edgePinEvent |=> edgePinIrqFlag)
    else $error("edge flag not set");

  a_periph_set: assert property (
    @(posedge core_clk) disable iff (!resetn)
    clkEn && (periphHwSet != '0)
    |=> ((periphFlags & $past(periphHwSet)) == $past(periphHwSet)))
    else $error("peripheral flag not set");

  // Both gates open (global gate alone for port change); the source bit then decides the request
  sequence periphGateS;
    clkEn && globalIrqEnable && peripheralIrqEnable;
  endsequence

  a_display_request: assert property (
    @(posedge core_clk) disable iff (!resetn)
    periphGateS ##0 (periphEn_reg[5] && periphFlags[5]) |=> irqRequest)
    else $error("display request missing");

  a_conv_request: assert property (
    @(posedge core_clk) disable iff (!resetn)
    periphGateS ##0 (periphEn_reg[4] && periphFlags[4]) |=> irqRequest)
    else $error("converter request missing");

  a_t1_request: assert property (
    @(posedge core_clk) disable iff (!resetn)
    periphGateS ##0 (periphEn_reg[0] && periphFlags[0]) |=> irqRequest)
    else $error("timer one request missing");

  a_serial_capture: assert property (
    @(posedge core_clk) disable iff (!resetn)
    periphGateS ##0 ((periphEn_reg[3:2] & periphFlags[3:2]) != 2'b00)
    |=> irqRequest)
    else $error("serial or capture request missing");

  a_port_request: assert property (
    @(posedge core_clk) disable iff (!resetn)
    clkEn && globalIrqEnable && portChangeIrqEnable && portChangeIrqFlag
    |=> irqRequest)
    else $error("port change request missing");

  // Bank mirrors of the enable address must not reach the enables
  a_pie_one_address: assert property (
    @(posedge core_clk) disable iff (!resetn)
    clkEn && regWrite && !pieSel |=> $stable(periphEn_reg))
    else $error("peripheral enables changed by another address");

  a_request_status: assert property (
    @(posedge core_clk) disable iff (!resetn)
    clkEn && requestRise |=> statusFlags[iefl_pkg::ST_REQUEST_BIT])
    else $error("request edge missing from status");

endmodule : iefl_top

/* test/iefl_src_model.sv */
// Model of the on-chip event sources that feed the flag logic
`timescale 1ns/1ps
module iefl_src_model (
  // Reset of the clock domain
  resetn,
  // Bench request, one bit per source
  evMask,
  // Event pulses toward the flag logic
  events
);
  input wire logic resetn;
  input wire logic [8:0] evMask;
  output logic [8:0] events;
  // Sources stay quiet in reset, so no flag is set as reset is released
  assign events = resetn ? evMask : 9'h000;
endmodule : iefl_src_model

/* test/tb.sv */
// Self-checking testbench for the interrupt enable and flag block
`timescale 1ns/1ps
module tb;
  // Clock, register port, events and counters
  logic core_clk, resetn, clkEn, regWrite, regRead;
  logic irqRequest, statusIrq;
  logic [8:0] regAddr, evMask, ev;
  logic [7:0] regWrData, regRdData;
  int failures, total_checks;
  iefl_src_model SRC (.resetn(resetn), .evMask(evMask), .events(ev));
  iefl_top DUT (.core_clk(core_clk), .resetn(resetn), .clkEn(clkEn),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .regRead(regRead), .regRdData(regRdData),
    .timerZeroOverflow(ev[8]), .edgePinEvent(ev[7]),
    .portChangeEvent(ev[6]), .displayEvent(ev[5]),
    .converterEvent(ev[4]), .serialPortEvent(ev[3]),
    .captureCompareEvent(ev[2]), .periodMatchEvent(ev[1]),
    .timerOneOverflow(ev[0]), .irqRequest(irqRequest),
    .statusIrq(statusIrq));
  // 125 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rdc(input logic [8:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1 chk(regRdData, exp);
  endtask : rdc
  task automatic fire(input logic [8:0] m);
    @(posedge core_clk);
    evMask <= m;
    @(posedge core_clk);
    evMask <= 9'h000;
  endtask : fire
  // Outputs trail the register state by one cycle
  task automatic settle;
    repeat (2) @(posedge core_clk);
    #1;
  endtask : settle
  task automatic t_reset;
    logic [8:0] as[7] = '{9'h00B, 9'h08B, 9'h08C, 9'h00C, 9'h1F0,
      9'h1F2, 9'h050};
    foreach (as[i]) rdc(as[i], 8'h00);
    chk({7'h00, irqRequest}, 8'h00);
    $display("test reset done");
  endtask : t_reset
  task automatic t_mirror;
    logic [8:0] as[4] = '{9'h00B, 9'h08B, 9'h10B, 9'h18B};
    wr(iefl_pkg::CORE_CTRL_B2, 8'h38);
    foreach (as[i]) rdc(as[i], 8'h38);
    // Write one bank and read another in the very next cycle
    @(posedge core_clk);
    regWrite <= 1'b1;
    regAddr <= iefl_pkg::CORE_CTRL_B0;
    regWrData <= 8'h28;
    @(posedge core_clk);
    regWrite <= 1'b0;
    regRead <= 1'b1;
    regAddr <= iefl_pkg::CORE_CTRL_B3;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1 chk(regRdData, 8'h28);
    wr(iefl_pkg::CORE_CTRL_B3, 8'h00);
    rdc(iefl_pkg::CORE_CTRL_B0, 8'h00);
    $display("test mirror done");
  endtask : t_mirror
  task automatic t_flags;
    fire(9'h1FF);
    repeat (3) @(posedge core_clk);
    rdc(iefl_pkg::CORE_CTRL_B1, 8'h07);
    rdc(iefl_pkg::PERIPH_FLAGS, 8'hCF);
    settle();
    chk({7'h00, irqRequest}, 8'h00);
    wr(iefl_pkg::CORE_CTRL_B0, 8'h00);
    wr(iefl_pkg::PERIPH_FLAGS, 8'h00);
    rdc(iefl_pkg::CORE_CTRL_B2, 8'h00);
    rdc(iefl_pkg::PERIPH_FLAGS, 8'h00);
    $display("test flags done");
  endtask : t_flags
  task automatic t_pie;
    wr(iefl_pkg::PERIPH_ENABLE, 8'hFF);
    rdc(iefl_pkg::PERIPH_ENABLE, 8'hCF);
    rdc(9'h10C, 8'h00);
    rdc(9'h00C, 8'h00);
    wr(iefl_pkg::PERIPH_ENABLE, 8'h00);
    wr(9'h18C, 8'hFF);
    rdc(iefl_pkg::PERIPH_ENABLE, 8'h00);
    $display("test enables done");
  endtask : t_pie
  task automatic t_request;
    int pb[6] = '{7, 6, 3, 2, 1, 0};
    logic [7:0] en, fl;
    for (int i = 0; i < 3; i++) begin
      en = 8'h20 >> i;
      fl = 8'h04 >> i;
      wr(iefl_pkg::CORE_CTRL_B0, 8'h00);
      wr(iefl_pkg::CORE_CTRL_B0, en);
      fire(9'h100 >> i);
      settle();
      chk({7'h00, irqRequest}, 8'h00);
      wr(iefl_pkg::CORE_CTRL_B0, 8'h80 | en | fl);
      settle();
      chk({7'h00, irqRequest}, 8'h01);
      wr(iefl_pkg::CORE_CTRL_B0, 8'h80 | fl);
      settle();
      chk({7'h00, irqRequest}, 8'h00);
    end
    // Flags set by software write, one source at a time
    foreach (pb[j]) begin
      en = 8'h01 << pb[j];
      wr(iefl_pkg::PERIPH_FLAGS, en);
      wr(iefl_pkg::PERIPH_ENABLE, en);
      wr(iefl_pkg::CORE_CTRL_B0, 8'h80);
      settle();
      chk({7'h00, irqRequest}, 8'h00);
      wr(iefl_pkg::CORE_CTRL_B0, 8'hC0);
      settle();
      chk({7'h00, irqRequest}, 8'h01);
      wr(iefl_pkg::PERIPH_ENABLE, ~en & 8'hCF);
      settle();
      chk({7'h00, irqRequest}, 8'h00);
      wr(iefl_pkg::PERIPH_FLAGS, 8'h00);
      wr(iefl_pkg::CORE_CTRL_B0, 8'h00);
    end
    $display("test request done");
  endtask : t_request
  task automatic t_status;
    logic [8:0] ms[4] = '{9'h100, 9'h080, 9'h040, 9'h002};
    wr(iefl_pkg::STATUS_CLEAR, 8'h1F);
    wr(iefl_pkg::STATUS_ENABLE, 8'h1F);
    rdc(iefl_pkg::STATUS_ENABLE, 8'h1F);
    foreach (ms[i]) begin
      fire(ms[i]);
      rdc(iefl_pkg::STATUS_EVENTS, 8'h01 << i);
      chk({7'h00, statusIrq}, 8'h01);
      wr(iefl_pkg::STATUS_CLEAR, 8'h01 << i);
      settle();
      chk({7'h00, statusIrq}, 8'h00);
    end
    // Masked event still latches in status
    wr(iefl_pkg::STATUS_ENABLE, 8'h1E);
    fire(9'h100);
    settle();
    chk({7'h00, statusIrq}, 8'h00);
    rdc(iefl_pkg::STATUS_EVENTS, 8'h01);
    rdc(iefl_pkg::STATUS_CLEAR, 8'h00);
    wr(iefl_pkg::STATUS_CLEAR, 8'h1F);
    $display("test status done");
  endtask : t_status
  task automatic t_race;
    wr(iefl_pkg::CORE_CTRL_B0, 8'h00);
    fork
      wr(iefl_pkg::CORE_CTRL_B0, 8'h00);
      fire(9'h100);
    join
    rdc(iefl_pkg::CORE_CTRL_B0, 8'h04);
    @(posedge core_clk);
    clkEn <= 1'b0;
    wr(iefl_pkg::CORE_CTRL_B0, 8'hFF);
    @(posedge core_clk);
    clkEn <= 1'b1;
    rdc(iefl_pkg::CORE_CTRL_B1, 8'h04);
    $display("test race done");
  endtask : t_race
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim
  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    failures++;
    end_sim();
  end
  // Reset for three cycles, then the tests in turn
  initial begin
    failures = 0;
    total_checks = 0;
    resetn = 1'b0;
    clkEn = 1'b1;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 9'h000;
    regWrData = 8'h00;
    evMask = 9'h000;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    t_reset();
    t_mirror();
    t_flags();
    t_pie();
    t_request();
    t_status();
    t_race();
    end_sim();
  end
endmodule : tb
